// File: hw/adc_status_flags.sv
/*
  Status and pending-flag view of the converter control logic, reached
  over an AHB-Lite slave port with zero wait states.
  Assumes all event inputs come from converter logic on clk_sys, one
  cycle pulses where marked, and that the bus master sends single words.
*/
`timescale 1ns/100ps
module adc_status_flags (
  input wire logic clk_sys,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter events, same clock
  input wire logic [11:0] timer_count,
  input wire logic timer_underflow,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic [2:0] conv_source,
  input wire logic conv_done,
  input wire logic cal_active,
  input wire logic sample_active,
  input wire logic queue_load,
  input wire logic sync_start_master,
  input wire logic sync_start_slave,
  input wire logic slave_done_in,
  input wire logic ms_mode_enter,
  input wire logic sync_sr_generated,
  input wire logic [15:0] timer_req_blocked,
  input wire logic [15:0] ext_req_blocked,
  input wire logic [15:0] channel_sr_in,
  input wire logic [3:0] source_sr_in
);
  import adc_status_pkg::*;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic lock_mode;
    logic external_event_participation;
    logic [11:0] lock_boundary_value;
    logic [11:0] timer_value;
    logic [3:0] current_channel_number;
    logic [2:0] current_trigger_source;
    logic arbitration_lock_status;
    logic cal;
    logic sample_phase_status;
    logic busy;
    logic [3:0] queue_level_pointer;
    logic queue_full;
    logic sync_requestor;
    logic sync_partner;
    logic master_finished;
    logic slave_finished;
    logic master_slave_active;
    logic [15:0] timer_pending_flag;
    logic [15:0] external_event_pending_flag;
    logic [15:0] channel_service_request_flag;
    logic [3:0] source_sr_flag;
  } state_s;

  state_s s;
  state_s next_s;
  logic [31:0] rd_word;
  logic [31:0] stat_word;
  logic addr_phase;
  logic [15:0] start_mask;
  logic lock_hit;
  logic q_start;

  // -----------------------------------------------------------------
  // status word assembly
  // -----------------------------------------------------------------
  // reserved bits stay zero since the word starts from zero
  always_comb
  begin
    stat_word = RST_WORD;
    stat_word[3:0] = s.current_channel_number;
    stat_word[POS_TRIGGER_SOURCE +: 3] = s.current_trigger_source;
    stat_word[POS_LOCK] = s.arbitration_lock_status;
    stat_word[POS_CAL] = s.cal;
    stat_word[POS_SAMPLE] = s.sample_phase_status;
    stat_word[POS_BUSY] = s.busy;
    stat_word[POS_QUEUE_LEVEL +: 4] = s.queue_level_pointer;
    stat_word[POS_QUEUE_FULL] = s.queue_full;
    stat_word[POS_SYNC_REQUESTOR] = s.sync_requestor;
    stat_word[POS_SYNC_PARTNER] = s.sync_partner;
    stat_word[POS_MASTER_FINISHED] = s.master_finished;
    stat_word[POS_SLAVE_FINISHED] = s.slave_finished;
    stat_word[POS_MS_ACTIVE] = s.master_slave_active;
  end

  // -----------------------------------------------------------------
  // read decode
  // -----------------------------------------------------------------
  // unmapped offsets read zero, still with an okay response
  always_comb
  begin
    rd_word = RST_WORD;
    if (haddr[7:0] == OFS_TIMER_VALUE_STATUS)
      rd_word[11:0] = s.timer_value;
    else if (haddr[7:0] == OFS_CONVERTER_STATUS)
      rd_word = stat_word;
    else if (haddr[7:0] == OFS_TIMER_REQUEST_PENDING)
      rd_word[15:0] = s.timer_pending_flag;
    else if (haddr[7:0] == OFS_EXT_EVENT_REQUEST_PENDING)
      rd_word[15:0] = s.external_event_pending_flag;
    else if (haddr[7:0] == OFS_CHANNEL_SR_STATUS)
      rd_word[15:0] = s.channel_service_request_flag;
    else if (haddr[7:0] == OFS_SOURCE_SR_STATUS)
      rd_word[3:0] = s.source_sr_flag;
    else if (haddr[7:0] == OFS_LOCK_CONTROL)
    begin
      rd_word[POS_CTL_LOCK_MODE] = s.lock_mode;
      rd_word[POS_CTL_EXT_PARTICIPATION] = s.external_event_participation;
      rd_word[POS_CTL_LOCK_BOUNDARY +: 12] = s.lock_boundary_value;
    end
  end

  assign addr_phase = hsel && htrans[1] && hready;
  assign start_mask = conv_start ? (16'h0001 << conv_channel) : 16'h0000;
  assign lock_hit = s.lock_mode && (timer_count == s.lock_boundary_value);
  assign q_start = conv_start && (conv_source == SRC_QUEUE);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  // one place computes every flag so set-over-clear priority is visible
  always_comb
  begin
    next_s = s;
    // bus side: read data is sampled at the address phase edge
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
    next_s.wr_pend = addr_phase && hwrite;
    next_s.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite)
      next_s.hrdata = rd_word;
    // only the control word is writable; status offsets drop writes
    if (s.wr_pend && (s.wr_addr == OFS_LOCK_CONTROL))
    begin
      next_s.lock_mode = hwdata[POS_CTL_LOCK_MODE];
      next_s.external_event_participation = hwdata[POS_CTL_EXT_PARTICIPATION];
      next_s.lock_boundary_value = hwdata[POS_CTL_LOCK_BOUNDARY +: 12];
    end
    next_s.timer_value = timer_count;
    // running conversion identity and busy
    if (conv_start)
    begin
      next_s.current_channel_number = conv_channel;
      next_s.current_trigger_source = conv_source;
    end
    if (conv_start)
      next_s.busy = 1'b1;
    else if (conv_done)
      next_s.busy = 1'b0;
    next_s.cal = cal_active;
    next_s.sample_phase_status = sample_active;
    // boundary hit beats an underflow in the same cycle
    if (lock_hit)
      next_s.arbitration_lock_status = 1'b1;
    else if (timer_underflow)
      next_s.arbitration_lock_status = 1'b0;
    // queue pointer saturates at depth; load and start together cancel
    if (queue_load && !q_start && (s.queue_level_pointer != QUEUE_DEPTH))
      next_s.queue_level_pointer = s.queue_level_pointer + 4'h1;
    else if (q_start && !queue_load && (s.queue_level_pointer != 4'h0))
      next_s.queue_level_pointer = s.queue_level_pointer - 4'h1;
    next_s.queue_full = (next_s.queue_level_pointer == QUEUE_DEPTH);
    // synchronized conversion roles end with the conversion
    if (sync_start_master)
      next_s.sync_requestor = 1'b1;
    else if (conv_done)
      next_s.sync_requestor = 1'b0;
    if (sync_start_slave)
      next_s.sync_partner = 1'b1;
    else if (conv_done)
      next_s.sync_partner = 1'b0;
    // finish marks live until the sync service request goes out
    if (conv_done && s.sync_requestor)
      next_s.master_finished = 1'b1;
    else if (sync_sr_generated)
      next_s.master_finished = 1'b0;
    if (slave_done_in)
      next_s.slave_finished = 1'b1;
    else if (sync_sr_generated)
      next_s.slave_finished = 1'b0;
    if (ms_mode_enter)
      next_s.master_slave_active = 1'b1;
    else if (sync_sr_generated)
      next_s.master_slave_active = 1'b0;
    // pending flags: a new blocked request wins over its own start
    next_s.timer_pending_flag = timer_req_blocked | (s.timer_pending_flag &
      ~((conv_source == SRC_TIMER) ? start_mask : 16'h0000));
    next_s.external_event_pending_flag = ext_req_blocked | (s.external_event_pending_flag &
      ~((conv_source == SRC_EXT_EVENT) ? start_mask : 16'h0000));
    // participation off holds the whole set at zero, even against new sets
    if (!s.external_event_participation)
      next_s.external_event_pending_flag = 16'h0000;
    next_s.channel_service_request_flag = channel_sr_in;
    next_s.source_sr_flag = source_sr_in;
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.lock_boundary_value <= RST_LOCK_BOUNDARY;
    end
    else
      s <= next_s;
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;

  // -----------------------------------------------------------------
  // assertions: bus side
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // zero wait states, so the master never stalls
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");

  // read data is the register seen at the address phase edge
  a_timer_read: assert property (addr_phase && !hwrite && haddr[7:0] == OFS_TIMER_VALUE_STATUS
    |=> hrdata == {20'h0_0000, $past(s.timer_value)})
    else $error("timer value read back wrong");

  // reserved status positions must never leak state
  a_reserved_zero: assert property (addr_phase && !hwrite && haddr[7:0] == OFS_CONVERTER_STATUS
    |=> hrdata[31:29] == 3'h0 && hrdata[23:21] == 3'h0 && hrdata[11] == 1'b0 && hrdata[7:4] == 4'h0)
    else $error("reserved status bits not zero");

  // a write to a status offset must leave control alone
  a_status_ro: assert property (s.wr_pend && s.wr_addr != OFS_LOCK_CONTROL
    |=> $stable(s.lock_boundary_value) && $stable(s.lock_mode))
    else $error("write to status changed control");

  // -----------------------------------------------------------------
  // assertions: running conversion
  // -----------------------------------------------------------------
  // the timer copy lags the converter by exactly one cycle
  a_timer_mirror: assert property (##1 s.timer_value == $past(timer_count))
    else $error("timer value not mirrored");

  a_channel_latch: assert property (conv_start |=> s.current_channel_number == $past(conv_channel)
    && s.current_trigger_source == $past(conv_source))
    else $error("channel or source not latched at start");

  // level inputs show up one cycle late, never earlier
  a_cal_mirror: assert property (##1 s.cal == $past(cal_active))
    else $error("calibration bit not following its level");

  a_sample_mirror: assert property (##1 s.sample_phase_status == $past(sample_active))
    else $error("sample bit not following its level");

  // busy must outlast the start until a done arrives
  a_busy_span: assert property (conv_start |=> s.busy ##1 (s.busy || $past(conv_done)))
    else $error("busy dropped without done");

  a_busy_end: assert property (conv_done && !conv_start |=> !s.busy)
    else $error("busy not cleared on done");

  // -----------------------------------------------------------------
  // assertions: arbitration lock
  // -----------------------------------------------------------------
  // a hit sets the bit whatever the underflow does alongside
  a_lock_window: assert property (lock_hit |=> s.arbitration_lock_status)
    else $error("lock bit not set at boundary");

  a_lock_clear: assert property (timer_underflow && !lock_hit |=> !s.arbitration_lock_status)
    else $error("lock bit not cleared on underflow");

  // -----------------------------------------------------------------
  // assertions: queue level
  // -----------------------------------------------------------------
  // a load without a start steps the pointer up by one below depth
  a_queue_step: assert property (queue_load && !q_start && s.queue_level_pointer != QUEUE_DEPTH
    |=> s.queue_level_pointer == $past(s.queue_level_pointer) + 4'h1)
    else $error("queue pointer did not step up");

  a_queue_down: assert property (q_start && !queue_load && s.queue_level_pointer != 4'h0
    |=> s.queue_level_pointer == $past(s.queue_level_pointer) - 4'h1)
    else $error("queue pointer did not step down");

  // no element beyond the last can ever be named
  a_queue_bound: assert property (s.queue_level_pointer <= QUEUE_DEPTH)
    else $error("queue pointer beyond depth");

  a_queue_full: assert property (s.queue_full == (s.queue_level_pointer == QUEUE_DEPTH))
    else $error("queue full disagrees with pointer");

  // filling the last empty element raises the full bit
  a_queue_fill: assert property (queue_load && !q_start && s.queue_level_pointer == QUEUE_DEPTH - 4'h1
    |=> s.queue_full)
    else $error("queue full not set on last load");

  // one start on a full queue frees an element again
  a_queue_free: assert property (q_start && !queue_load && s.queue_full |=> !s.queue_full)
    else $error("queue full not cleared by start");

  // -----------------------------------------------------------------
  // assertions: synchronized conversion
  // -----------------------------------------------------------------
  // a new start in the same cycle keeps the role bit
  a_sync_master: assert property (sync_start_master |=> s.sync_requestor)
    else $error("requestor bit not set");

  a_sync_slave: assert property (sync_start_slave |=> s.sync_partner)
    else $error("partner bit not set");

  a_partner_end: assert property (conv_done && !sync_start_slave |=> !s.sync_partner)
    else $error("partner bit not cleared on done");

  a_sync_finish: assert property (s.sync_requestor && conv_done && !sync_start_master
    |=> s.master_finished && !s.sync_requestor)
    else $error("master finish not recorded");

  // the opposite module's done is taken as it comes
  a_slave_finish: assert property (slave_done_in |=> s.slave_finished)
    else $error("slave finish not recorded");

  a_ms_enter: assert property (ms_mode_enter |=> s.master_slave_active)
    else $error("master slave bit not set");

  a_ms_active: assert property (sync_sr_generated && !ms_mode_enter && !(conv_done && s.sync_requestor)
    |=> !s.master_slave_active && !s.master_finished)
    else $error("sync flags not cleared by service request");

  // -----------------------------------------------------------------
  // assertions: pending and service request flags
  // -----------------------------------------------------------------
  a_timer_pend: assert property (timer_req_blocked[0] |=> s.timer_pending_flag[0])
    else $error("timer pending not set");

  // a start of the same channel drops its own flag
  a_timer_clear: assert property (conv_start && conv_source == SRC_TIMER && conv_channel == 4'h0
    && !timer_req_blocked[0] |=> !s.timer_pending_flag[0])
    else $error("timer pending not cleared by start");

  a_ext_set: assert property (ext_req_blocked[7] && s.external_event_participation
    |=> s.external_event_pending_flag[7])
    else $error("external pending not set");

  a_ext_clear: assert property (conv_start && conv_source == SRC_EXT_EVENT && conv_channel == 4'h7
    && !ext_req_blocked[7] |=> !s.external_event_pending_flag[7])
    else $error("external pending not cleared by start");

  a_ext_drop: assert property (!s.external_event_participation |=> s.external_event_pending_flag == 16'h0000)
    else $error("external pending survives participation off");

  // service request views copy their inputs, no software clear
  a_channel_sr: assert property (##1 s.channel_service_request_flag == $past(channel_sr_in))
    else $error("channel service status not following input");

  a_source_sr: assert property (##1 s.source_sr_flag == $past(source_sr_in))
    else $error("source service status not following input");

  // -----------------------------------------------------------------
  // coverage of the main scenarios
  // -----------------------------------------------------------------
  c_conversion: cover property (conv_start ##[1:20] conv_done);
  c_queue_fill: cover property (s.queue_full);
  c_sync_round: cover property (ms_mode_enter ##[1:50] sync_sr_generated);
  c_ext_serviced: cover property (s.external_event_pending_flag[7] && conv_start
    && conv_source == SRC_EXT_EVENT && conv_channel == 4'h7);
  c_lock_release: cover property (s.arbitration_lock_status && timer_underflow);
endmodule

// File: hw/adc_status_pkg.sv
/*
  Constants for the converter status view: register byte offsets, field
  positions, reset values and source encodings.
  Assumes a 32-bit AHB-Lite slave port and one 100 MHz module clock.
*/
package adc_status_pkg;
  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_VALUE_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONVERTER_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMER_REQUEST_PENDING = 8'h08;
  localparam logic [7:0] OFS_EXT_EVENT_REQUEST_PENDING = 8'h0C;
  localparam logic [7:0] OFS_CHANNEL_SR_STATUS = 8'h10;
  localparam logic [7:0] OFS_SOURCE_SR_STATUS = 8'h14;
  localparam logic [7:0] OFS_LOCK_CONTROL = 8'h18;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int POS_TRIGGER_SOURCE = 8;
  localparam int POS_LOCK = 12;
  localparam int POS_CAL = 13;
  localparam int POS_SAMPLE = 14;
  localparam int POS_BUSY = 15;
  localparam int POS_QUEUE_LEVEL = 16;
  localparam int POS_QUEUE_FULL = 20;
  localparam int POS_SYNC_REQUESTOR = 24;
  localparam int POS_SYNC_PARTNER = 25;
  localparam int POS_MASTER_FINISHED = 26;
  localparam int POS_SLAVE_FINISHED = 27;
  localparam int POS_MS_ACTIVE = 28;
  localparam int POS_CTL_LOCK_MODE = 0;
  localparam int POS_CTL_EXT_PARTICIPATION = 1;
  localparam int POS_CTL_LOCK_BOUNDARY = 16;
  // -----------------------------------------------------------------
  // reset values and sizes
  // -----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [11:0] RST_LOCK_BOUNDARY = 12'h000;
  localparam logic [3:0] QUEUE_DEPTH = 4'h8;
  // trigger source codes
  localparam logic [2:0] SRC_INJECTION = 3'h0;
  localparam logic [2:0] SRC_TIMER = 3'h1;
  localparam logic [2:0] SRC_SYNC_INJECTION = 3'h2;
  localparam logic [2:0] SRC_EXT_EVENT = 3'h3;
  localparam logic [2:0] SRC_SOFTWARE = 3'h4;
  localparam logic [2:0] SRC_QUEUE = 3'h6;
  localparam logic [2:0] SRC_AUTOSCAN = 3'h7;
endpackage

// File: bench/testbench.sv
/*
  Self-checking bench for the converter status view: bus master tasks,
  converter event stimulus and one scenario task per behaviour.
  Assumes the design answers single-word AHB-Lite transfers with no wait states.
*/
`timescale 1ns/100ps
module testbench;
  import adc_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [11:0] timer_count = 12'h000;
  logic timer_underflow = 1'b0, conv_start = 1'b0, conv_done = 1'b0, cal_active = 1'b0;
  logic sample_active = 1'b0, queue_load = 1'b0, sync_start_master = 1'b0, sync_start_slave = 1'b0;
  logic slave_done_in = 1'b0, ms_mode_enter = 1'b0, sync_sr_generated = 1'b0;
  logic [3:0] conv_channel = 4'h0, source_sr_in = 4'h0;
  logic [2:0] conv_source = 3'h0;
  logic [15:0] timer_req_blocked = 16'h0, ext_req_blocked = 16'h0, channel_sr_in = 16'h0;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #5 clk_sys = ~clk_sys;
  adc_status_flags i_dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_count(timer_count), .timer_underflow(timer_underflow),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_source(conv_source),
    .conv_done(conv_done), .cal_active(cal_active), .sample_active(sample_active),
    .queue_load(queue_load), .sync_start_master(sync_start_master), .sync_start_slave(sync_start_slave),
    .slave_done_in(slave_done_in), .ms_mode_enter(ms_mode_enter), .sync_sr_generated(sync_sr_generated),
    .timer_req_blocked(timer_req_blocked), .ext_req_blocked(ext_req_blocked),
    .channel_sr_in(channel_sr_in), .source_sr_in(source_sr_in));
  // ---------------------------------------------------------------
  // reporting and comparison
  // ---------------------------------------------------------------
  task end_of_test;
    begin
      if (err_count == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    begin
      tests_run++;
      if ((got & mask) !== (exp & mask))
      begin
        err_count++;
        $display("ERROR %0t got %h expected %h mask %h", $time, got, exp, mask);
      end
    end
  endtask
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_of_test;
    end
  end
  // ---------------------------------------------------------------
  // bus master, entered just after a rising edge
  // ---------------------------------------------------------------
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      d = hrdata;
      chk({31'h0, hresp}, 32'h0, 32'h1);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] x;
    begin
      bus(1'b0, a, 32'h0, x);
      chk(x, exp, mask);
    end
  endtask
  // one-cycle conversion start with channel and source alongside
  task start(input logic [3:0] ch, input logic [2:0] src);
    begin
      conv_start <= 1'b1;
      conv_channel <= ch;
      conv_source <= src;
      @(posedge clk_sys);
      conv_start <= 1'b0;
    end
  endtask
  task done;
    begin
      conv_done <= 1'b1;
      @(posedge clk_sys);
      conv_done <= 1'b0;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset_and_writes;
    begin
      for (int a = 0; a < 8; a++) rchk(8'(a * 4), RST_WORD, 32'hFFFF_FFFF);
      timer_count <= 12'hABC;
      for (int a = 0; a < 6; a++) wr(8'(a * 4), 32'hFFFF_FFFF);
      rchk(OFS_TIMER_VALUE_STATUS, 32'h0000_0ABC, 32'hFFFF_FFFF);
      rchk(OFS_CONVERTER_STATUS, 32'h0, 32'hFFFF_FFFF);
      rchk(OFS_SOURCE_SR_STATUS, 32'h0, 32'hFFFF_FFFF);
    end
  endtask
  task t_conversion;
    logic [3:0] ch;
    begin
      for (int s = 0; s < 8; s++)
      begin
        ch = s[0] ? 4'hF : 4'h0;
        start(ch, 3'(s));
        rchk(OFS_CONVERTER_STATUS, {16'h0, 1'b1, 4'h0, 3'(s), 4'h0, ch}, 32'h0000_8F0F);
      end
      done;
      rchk(OFS_CONVERTER_STATUS, 32'h0, 32'h0000_8000);
      for (int k = 1; k < 4; k++)
      begin
        cal_active <= k[0];
        sample_active <= k[1];
        @(posedge clk_sys);
        rchk(OFS_CONVERTER_STATUS, 32'(k) << POS_CAL, 32'h0000_6000);
      end
      cal_active <= 1'b0;
      sample_active <= 1'b0;
    end
  endtask
  task t_lock;
    begin
      wr(OFS_LOCK_CONTROL, 32'h0123_0000);
      timer_count <= 12'h123;
      @(posedge clk_sys);
      rchk(OFS_CONVERTER_STATUS, 32'h0, 32'h0000_1000);
      wr(OFS_LOCK_CONTROL, 32'h0123_0001);
      rchk(OFS_LOCK_CONTROL, 32'h0123_0001, 32'h0FFF_0003);
      rchk(OFS_CONVERTER_STATUS, 32'h0000_1000, 32'h0000_1000);
      timer_count <= 12'h122;
      timer_underflow <= 1'b1;
      @(posedge clk_sys);
      timer_underflow <= 1'b0;
      rchk(OFS_CONVERTER_STATUS, 32'h0, 32'h0000_1000);
      wr(OFS_LOCK_CONTROL, 32'h0);
    end
  endtask
  task t_queue;
    begin
      // one load beyond depth, the pointer must saturate
      queue_load <= 1'b1;
      repeat (9) @(posedge clk_sys);
      queue_load <= 1'b0;
      rchk(OFS_CONVERTER_STATUS, 32'h0018_0000, 32'h001F_0000);
      start(4'h3, SRC_QUEUE);
      rchk(OFS_CONVERTER_STATUS, 32'h0007_0000, 32'h001F_0000);
    end
  endtask
  task t_sync;
    begin
      ms_mode_enter <= 1'b1;
      @(posedge clk_sys);
      ms_mode_enter <= 1'b0;
      sync_start_master <= 1'b1;
      @(posedge clk_sys);
      sync_start_master <= 1'b0;
      rchk(OFS_CONVERTER_STATUS, 32'h1100_0000, 32'h1F00_0000);
      done;
      rchk(OFS_CONVERTER_STATUS, 32'h1400_0000, 32'h1F00_0000);
      slave_done_in <= 1'b1;
      @(posedge clk_sys);
      slave_done_in <= 1'b0;
      rchk(OFS_CONVERTER_STATUS, 32'h1C00_0000, 32'h1F00_0000);
      sync_sr_generated <= 1'b1;
      @(posedge clk_sys);
      sync_sr_generated <= 1'b0;
      sync_start_slave <= 1'b1;
      @(posedge clk_sys);
      sync_start_slave <= 1'b0;
      rchk(OFS_CONVERTER_STATUS, 32'h0200_0000, 32'h1F00_0000);
      done;
      rchk(OFS_CONVERTER_STATUS, 32'h0, 32'h1F00_0000);
    end
  endtask
  task t_pending;
    begin
      timer_req_blocked <= 16'h8001;
      @(posedge clk_sys);
      timer_req_blocked <= 16'h0;
      rchk(OFS_TIMER_REQUEST_PENDING, 32'h0000_8001, 32'hFFFF_FFFF);
      start(4'h0, SRC_TIMER);
      rchk(OFS_TIMER_REQUEST_PENDING, 32'h0000_8000, 32'hFFFF_FFFF);
      ext_req_blocked <= 16'h0081;
      @(posedge clk_sys);
      rchk(OFS_EXT_EVENT_REQUEST_PENDING, 32'h0, 32'hFFFF_FFFF);
      wr(OFS_LOCK_CONTROL, 32'h0000_0002);
      @(posedge clk_sys);
      ext_req_blocked <= 16'h0;
      rchk(OFS_EXT_EVENT_REQUEST_PENDING, 32'h0000_0081, 32'hFFFF_FFFF);
      start(4'h7, SRC_EXT_EVENT);
      rchk(OFS_EXT_EVENT_REQUEST_PENDING, 32'h0000_0001, 32'hFFFF_FFFF);
      wr(OFS_LOCK_CONTROL, 32'h0);
      // the flags drop one edge after participation does
      @(posedge clk_sys);
      rchk(OFS_EXT_EVENT_REQUEST_PENDING, 32'h0, 32'hFFFF_FFFF);
    end
  endtask
  task t_service;
    begin
      channel_sr_in <= 16'hA5C3;
      source_sr_in <= 4'h9;
      @(posedge clk_sys);
      wr(OFS_CHANNEL_SR_STATUS, 32'h0);
      rchk(OFS_CHANNEL_SR_STATUS, 32'h0000_A5C3, 32'hFFFF_FFFF);
      rchk(OFS_SOURCE_SR_STATUS, 32'h0000_0009, 32'hFFFF_FFFF);
      source_sr_in <= 4'h6;
      @(posedge clk_sys);
      rchk(OFS_SOURCE_SR_STATUS, 32'h0000_0006, 32'hFFFF_FFFF);
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset_and_writes;
    t_conversion;
    t_lock;
    t_queue;
    t_sync;
    t_pending;
    t_service;
    end_of_test;
  end
endmodule
